// file: rtl/mcsfr_consts.svh
// Offsets, field positions and reset values of the core special-function logic
`ifndef MCSFR_CONSTS_SVH
`define MCSFR_CONSTS_SVH

// File addresses inside one bank
`define MCSFR_ADDR_INDIRECT 5'h00
`define MCSFR_ADDR_PC_LOW   5'h02
`define MCSFR_ADDR_STATUS   5'h03
`define MCSFR_ADDR_POINTER  5'h04
`define MCSFR_ADDR_TRIM     5'h05

// Status flag register fields
`define MCSFR_ST_WAKE  7
`define MCSFR_ST_PAGE  5
`define MCSFR_ST_TO    4
`define MCSFR_ST_PD    3
`define MCSFR_ST_ZERO  2
`define MCSFR_ST_DC    1
`define MCSFR_ST_CARRY 0

// Timer and wake configuration fields
`define MCSFR_CFG_WAKE   7
`define MCSFR_CFG_PULL   6
`define MCSFR_CFG_SRC    5
`define MCSFR_CFG_EDGE   4
`define MCSFR_CFG_ASSIGN 3
`define MCSFR_CFG_RESET  8'hFF

// Program counter fields and reset values
`define MCSFR_PC_PAGE   9
`define MCSFR_PC_RESET  12'hFFF
`define MCSFR_PTR_RESET 7'h40
`define MCSFR_TRIM_RESET 6'h20

`endif

// file: rtl/mcsfr_core.sv
// Core special-function registers, program counter and indirect addressing
//
// Operation
// - Jumps take program counter bit 9 from the page select bit.
// - Rotate right or left loads carry with operand bit 0 or bit 7.
// - Load-config copies the working register into all configuration bits.
// - Every reset sets all configuration bits to one.
// - A pin set as output loses wake-on-change and pull-up.
// - Configuration bit 7 low enables wake-on-change on the four wake pins.
// - Configuration bit 6 low enables pull-ups on the four wake pins.
// - Configuration bit 5 high clocks the timer from its external pin.
// - Configuration bit 4 high counts falling edges, low counts rising edges.
// - Configuration bit 3 high gives the prescaler to the watchdog.
// - Prescale field divides by 2^(n+1) for timer, 2^n for watchdog.
// - Trim register holds six bits in 7..2; bits 1..0 read zero.
// - Program counter advances by one unless an instruction loads it.
// - Jumps load counter bits 8..0 from the instruction address field.
// - Calls and low-latch writes load bits 7..0 and clear bit 8.
// - Reset sets the counter to all ones; it then rolls to zero.
// - Every reset clears the page select bit.
// - Extra returns keep giving level 2; no overflow or underflow flag.
// - The indirect window address reaches the register the pointer names.
// - Pointer at the window: reads give zero, writes do nothing.
// - Computed zero, digit carry and carry override data writes to them.
// - Wake-reset flag is set by pin-change wake reset, else cleared.
// - Pointer bits 4..0 select one of 32 addresses.
// - Pointer bits 6..5 select one of four banks.
`timescale 1ns/1ps
`include "mcsfr_consts.svh"
module mcsfr_core (
	input  wire logic                clock,             // Instruction cycle clock
	input  wire logic                rst,               // Synchronous reset, active high
	input  wire logic                rst_por,           // Reset source is power-on
	input  wire logic                rst_wake,          // Reset source is pin-change wake
	input  wire logic                wdt_timeout,       // Watchdog expired, pulse
	input  wire mcsfr_pkg::mcsfr_op_t op,               // Decoded instruction
	input  wire logic [8:0]          insn_addr,         // Jump address field
	input  wire logic [7:0]          insn_lit,          // Call or literal field
	input  wire logic [7:0]          w_in,              // Working register value
	input  wire logic [7:0]          alu_operand,       // Operand of a rotate
	input  wire logic [4:0]          file_addr,         // Direct file address
	input  wire logic                file_we,           // Destination write strobe
	input  wire logic [7:0]          file_wdata,        // Destination write data
	input  wire logic [2:0]          flags_upd,         // Zero, digit carry, carry update
	input  wire logic [2:0]          flags_val,         // Computed zero, digit carry, carry
	input  wire logic [3:0]          direction_control, // Wake pin directions, 1 is input
	input  wire logic [7:0]          mem_rdata,         // Data memory read data
	output logic [7:0]               rd_data,           // File read data
	output logic [6:0]               mem_addr,          // Data memory address
	output logic                     mem_we,            // Data memory write strobe
	output logic [7:0]               mem_wdata,         // Data memory write data
	output mcsfr_pkg::mcsfr_pc_t     pc,                // Program counter
	output logic                     w_load,            // Literal load of working reg
	output logic [7:0]               w_load_value,      // Literal to load
	output logic [3:0]               wake_enable,       // Wake-on-change per wake pin
	output logic [3:0]               pullup_enable,     // Weak pull-up per wake pin
	output logic                     timer_source_select, // Timer from external pin
	output logic                     timer_edge_select,   // Count falling external edges
	output logic                     prescaler_assign,    // Prescaler on watchdog
	output logic [3:0]               timer_prescale_log2, // Timer divide, log2
	output logic [3:0]               wdt_prescale_log2,   // Watchdog divide, log2
	output logic [5:0]               osc_trim_value       // Oscillator calibration
);
	import mcsfr_pkg::*;

	logic [7:0] timer_wake_config;
	logic [6:0] pointer_register;
	logic [5:0] osc_trim;
	logic       wake_reset_flag;
	logic       page_select_bit;
	logic       timeout_flag;
	logic       powerdown_flag;
	logic       zero_flag;
	logic       digit_carry_flag;
	logic       carry_flag;
	mcsfr_pc_t  next_pc;
	mcsfr_pc_t  pc_plus1;

	mcsfr_stack_if stk ();

	mcsfr_stack u_stack (
		.clock (clock),
		.rst   (rst),
		.stk   (stk)
	);

	////////////////////////////////////////////////////////////////////////
	// Address decode; indirect accesses use pointer bank and offset
	wire       indirect    = (file_addr == `MCSFR_ADDR_INDIRECT);
	wire [6:0] eff_addr    = indirect ? pointer_register : {2'b00, file_addr};
	wire [4:0] eff_low     = eff_addr[4:0];
	wire       null_access = (eff_low == `MCSFR_ADDR_INDIRECT);
	wire       hit_pcl     = (eff_low == `MCSFR_ADDR_PC_LOW);
	wire       hit_status  = (eff_low == `MCSFR_ADDR_STATUS);
	wire       hit_pointer = (eff_low == `MCSFR_ADDR_POINTER);
	wire       hit_trim    = (eff_low == `MCSFR_ADDR_TRIM);
	wire       sfr_hit     = hit_pcl | hit_status | hit_pointer | hit_trim;
	wire       pcl_wr      = file_we & hit_pcl;
	wire       status_wr   = file_we & hit_status;
	wire       pointer_wr  = file_we & hit_pointer;
	wire       trim_wr     = file_we & hit_trim;

	// Everything not held here goes out to the data memory bus
	assign mem_addr  = eff_addr;
	assign mem_we    = file_we & ~sfr_hit & ~null_access;
	assign mem_wdata = file_wdata;

	////////////////////////////////////////////////////////////////////////
	// Read mux; unimplemented bits read zero, except pointer bit 7, which reads one
	wire [7:0] status_rd = {wake_reset_flag, 1'b0, page_select_bit, timeout_flag,
		powerdown_flag, zero_flag, digit_carry_flag, carry_flag};
	wire [7:0] sfr_rd = hit_pcl ? pc[7:0] :
		hit_status  ? status_rd :
		hit_pointer ? {1'b1, pointer_register} :
		{osc_trim, 2'b00};
	assign rd_data = null_access ? 8'h00 : (sfr_hit ? sfr_rd : mem_rdata);

	////////////////////////////////////////////////////////////////////////
	// Program counter selection; page bit feeds bit 9 of a jump, call or low-latch load; returns take the stack value
	wire is_goto  = (op == MCSFR_OP_GOTO);
	wire is_call  = (op == MCSFR_OP_CALL);
	wire is_return_literal_insn = (op == MCSFR_OP_RETURN_LITERAL_INSN);
	wire [2:0] pc_hi = {pc[11:10], page_select_bit};

	assign pc_plus1      = pc + 12'h001;
	assign stk.push      = is_call;
	assign stk.pop       = is_return_literal_insn;
	assign stk.push_addr = pc_plus1;

	always_comb begin
		case (op)
			MCSFR_OP_GOTO:  next_pc = {pc_hi, insn_addr};
			MCSFR_OP_CALL:  next_pc = {pc_hi, 1'b0, insn_lit};
			MCSFR_OP_RETURN_LITERAL_INSN: next_pc = stk.top;
			default:        next_pc = pcl_wr ? {pc_hi, 1'b0, file_wdata} : pc_plus1;
		endcase
	end

	// Reset vector is the last location; increment wraps it to zero
	always_ff @(posedge clock) begin
		if (rst) begin
			pc <= `MCSFR_PC_RESET;
		end else begin
			pc <= next_pc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Literal return loads the working register one cycle later
	always_ff @(posedge clock) begin
		if (rst) begin
			w_load       <= 1'b0;
			w_load_value <= 8'h00;
		end else begin
			w_load       <= is_return_literal_insn;
			w_load_value <= insn_lit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status: page and wake flag follow writes; flags follow the ALU first
	wire rot_c = (op == MCSFR_OP_RRF) ? alu_operand[0] : alu_operand[7];
	wire rot   = (op == MCSFR_OP_RRF) | (op == MCSFR_OP_RLF);

	// Any computed flag or rotate shuts the data path to all three flags, so a
	// status destination keeps the untouched flags instead of the written data
	wire arith_wr = status_wr & ~(|flags_upd) & ~rot;

	always_ff @(posedge clock) begin
		if (rst) begin
			page_select_bit <= 1'b0;
			wake_reset_flag <= rst_wake;
		end else if (status_wr) begin
			page_select_bit <= file_wdata[`MCSFR_ST_PAGE];
			wake_reset_flag <= file_wdata[`MCSFR_ST_WAKE];
		end
	end

	// Data writes to the three arithmetic flags lose to computed values
	always_ff @(posedge clock) begin
		if (rst) begin
			zero_flag        <= 1'b0;
			digit_carry_flag <= 1'b0;
			carry_flag       <= 1'b0;
		end else begin
			if (flags_upd[2]) zero_flag <= flags_val[2];
			else if (arith_wr) zero_flag <= file_wdata[`MCSFR_ST_ZERO];
			if (flags_upd[1]) digit_carry_flag <= flags_val[1];
			else if (arith_wr) digit_carry_flag <= file_wdata[`MCSFR_ST_DC];
			if (rot) carry_flag <= rot_c;
			else if (flags_upd[0]) carry_flag <= flags_val[0];
			else if (arith_wr) carry_flag <= file_wdata[`MCSFR_ST_CARRY];
		end
	end

	// Timeout and power-down ignore data writes; non-power-on resets hold them
	always_ff @(posedge clock) begin
		if (rst) begin
			if (rst_por) begin
				timeout_flag   <= 1'b1;
				powerdown_flag <= 1'b1;
			end
		end else if (wdt_timeout) begin
			timeout_flag <= 1'b0;
		end else if (op == MCSFR_OP_SLEEP) begin
			timeout_flag   <= 1'b1;
			powerdown_flag <= 1'b0;
		end else if (op == MCSFR_OP_CLRWDT) begin
			timeout_flag   <= 1'b1;
			powerdown_flag <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pointer, trim and write-only configuration
	always_ff @(posedge clock) begin
		if (rst) begin
			pointer_register  <= `MCSFR_PTR_RESET;
			osc_trim          <= `MCSFR_TRIM_RESET;
			timer_wake_config <= `MCSFR_CFG_RESET;
		end else begin
			if (pointer_wr) pointer_register <= file_wdata[6:0];
			if (trim_wr) osc_trim <= file_wdata[7:2];
			if (op == MCSFR_OP_CONFIG) timer_wake_config <= w_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration decode; an output-driven pin overrides wake and pull-up
	wire cfg_wake_off = timer_wake_config[`MCSFR_CFG_WAKE];
	wire cfg_pull_off = timer_wake_config[`MCSFR_CFG_PULL];
	wire [3:0] rate   = {1'b0, timer_wake_config[2:0]};

	assign wake_enable         = direction_control & {4{~cfg_wake_off}};
	assign pullup_enable       = direction_control & {4{~cfg_pull_off}};
	assign timer_source_select = timer_wake_config[`MCSFR_CFG_SRC];
	assign timer_edge_select   = timer_wake_config[`MCSFR_CFG_EDGE];
	assign prescaler_assign    = timer_wake_config[`MCSFR_CFG_ASSIGN];
	assign timer_prescale_log2 = prescaler_assign ? 4'h0 : rate + 4'h1;
	assign wdt_prescale_log2   = prescaler_assign ? rate : 4'h0;
	assign osc_trim_value      = osc_trim;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	goto_load_a: assert property (is_goto |=>
		pc[9] == $past(page_select_bit) && pc[8:0] == $past(insn_addr))
		else $error("jump did not load page and address");
	rot_right_a: assert property (op == MCSFR_OP_RRF |=>
		carry_flag == $past(alu_operand[0]))
		else $error("rotate right did not load carry");
	rot_left_a: assert property (op == MCSFR_OP_RLF |=>
		carry_flag == $past(alu_operand[7]))
		else $error("rotate left did not load carry");
	config_load_a: assert property (op == MCSFR_OP_CONFIG |=>
		{timer_source_select, timer_edge_select, prescaler_assign, rate[2:0]}
		== $past(w_in[5:0]))
		else $error("config load mismatch");
	reset_state_a: assert property (
		@(posedge clock) disable iff (1'b0) rst |=>
		timer_wake_config == `MCSFR_CFG_RESET && pc == `MCSFR_PC_RESET
		&& !page_select_bit && wake_reset_flag == $past(rst_wake))
		else $error("reset state wrong");
	output_pin_a: assert property ((wake_enable & ~direction_control) == 4'h0
		and (pullup_enable & ~direction_control) == 4'h0
		and (cfg_wake_off |-> wake_enable == 4'h0)
		and (cfg_pull_off |-> pullup_enable == 4'h0))
		else $error("wake or pull-up on an output pin");
	prescale_a: assert property (!prescaler_assign |->
		timer_prescale_log2 == rate + 4'h1 && wdt_prescale_log2 == 4'h0)
		else $error("timer prescale not 2^(n+1)");
	pc_step_a: assert property (op == MCSFR_OP_NONE && !pcl_wr |=>
		pc == $past(pc) + 12'h001)
		else $error("counter did not advance by one");
	call_load_a: assert property (is_call |=>
		pc[8] == 1'b0 && pc[7:0] == $past(insn_lit) && stk.top == $past(pc) + 12'h001)
		else $error("call load wrong");
	call_return_a: assert property (is_call ##1 is_return_literal_insn |=>
		pc == $past(pc, 2) + 12'h001 && w_load && w_load_value == $past(insn_lit))
		else $error("return did not come back after call");
	null_window_a: assert property (null_access |-> rd_data == 8'h00 && !mem_we)
		else $error("pointer at window not null");
	indirect_a: assert property (indirect && !sfr_hit && !null_access |->
		mem_addr == pointer_register && mem_we == file_we)
		else $error("indirect access misrouted");
	flag_block_a: assert property (status_wr && flags_upd[2] |=>
		zero_flag == $past(flags_val[2]))
		else $error("data write beat computed zero flag");
	// A zero-only update must also keep the data off digit carry and carry
	flag_hold_a: assert property (status_wr && flags_upd == 3'b100 && !rot |=>
		digit_carry_flag == $past(digit_carry_flag) && carry_flag == $past(carry_flag))
		else $error("data write reached a flag while another was computed");
	status_read_a: assert property (hit_status && !null_access |->
		rd_data[6] == 1'b0 && rd_data[4] == timeout_flag)
		else $error("status bit 6 not zero");
	trim_read_a: assert property (hit_trim && !null_access |-> rd_data[1:0] == 2'b00)
		else $error("trim low bits not zero");
	tpd_ro_a: assert property (status_wr && op == MCSFR_OP_NONE && !wdt_timeout |=>
		$stable(timeout_flag) && $stable(powerdown_flag))
		else $error("timeout or power-down written by data");
	tpd_wdt_a: assert property (wdt_timeout |=> !timeout_flag)
		else $error("watchdog expiry did not clear timeout");

	cover property (is_call ##1 is_call ##1 is_return_literal_insn ##1 is_return_literal_insn ##1 is_return_literal_insn);
	cover property (indirect && file_we && mem_we);
	cover property (op == MCSFR_OP_CONFIG ##1 !prescaler_assign);
	cover property (pcl_wr ##1 pc[8] == 1'b0);
endmodule

// file: rtl/mcsfr_pkg.sv
// Types shared by the core special-function logic
package mcsfr_pkg;
	typedef logic [11:0] mcsfr_pc_t;
	typedef enum logic [3:0] {
		MCSFR_OP_NONE,
		MCSFR_OP_GOTO,
		MCSFR_OP_CALL,
		MCSFR_OP_RETURN_LITERAL_INSN,
		MCSFR_OP_CONFIG,
		MCSFR_OP_RRF,
		MCSFR_OP_RLF,
		MCSFR_OP_SLEEP,
		MCSFR_OP_CLRWDT
	} mcsfr_op_t;
endpackage

// file: rtl/mcsfr_stack.sv
// Two-level return address stack
`timescale 1ns/1ps
module mcsfr_stack (
	input  wire logic     clock, // Instruction cycle clock
	input  wire logic     rst,   // Synchronous reset, active high
	mcsfr_stack_if.stack  stk    // Push and pop from the core
);
	import mcsfr_pkg::*;

	mcsfr_pc_t level1;
	mcsfr_pc_t level2;

	assign stk.top = level1;

	////////////////////////////////////////////////////////////////////////
	// Push shifts down, pop shifts up; level 2 keeps its value on pop
	always_ff @(posedge clock) begin
		if (rst) begin
			level1 <= 12'h000;
			level2 <= 12'h000;
		end else if (stk.push) begin
			level1 <= stk.push_addr;
			level2 <= level1;
		end else if (stk.pop) begin
			level1 <= level2;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	pop_refill_a: assert property (@(posedge clock) disable iff (rst)
		stk.pop && !stk.push |=> level1 == $past(level2) && $stable(level2))
		else $error("pop did not refill level 1 from level 2");
	push_shift_a: assert property (@(posedge clock) disable iff (rst)
		stk.push |=> level2 == $past(level1) && level1 == $past(stk.push_addr))
		else $error("push did not shift the stack");
	cover property (@(posedge clock) disable iff (rst) stk.push ##1 stk.push ##1 stk.push);
endmodule

// file: rtl/mcsfr_stack_if.sv
// Push and pop signals between the core and its return stack
`timescale 1ns/1ps
interface mcsfr_stack_if;
	logic                push;
	logic                pop;
	mcsfr_pkg::mcsfr_pc_t push_addr;
	mcsfr_pkg::mcsfr_pc_t top;
	modport core  (output push, output pop, output push_addr, input top);
	modport stack (input push, input pop, input push_addr, output top);
endinterface

// file: tb/mcsfr_core_test.sv
// Self-checking testbench of the core special-function logic
`timescale 1ns/1ps
`include "mcsfr_consts.svh"
module mcsfr_core_test;
	import mcsfr_pkg::*;

	logic                 clock;
	logic                 rst;
	logic                 rst_por;
	logic                 rst_wake;
	logic                 wdt_timeout;
	mcsfr_op_t            op;
	logic [8:0]           insn_addr;
	logic [7:0]           insn_lit;
	logic [7:0]           w_in;
	logic [7:0]           alu_operand;
	logic [4:0]           file_addr;
	logic                 file_we;
	logic [7:0]           file_wdata;
	logic [2:0]           flags_upd;
	logic [2:0]           flags_val;
	logic [3:0]           direction_control;
	logic [7:0]           mem_rdata;
	logic [7:0]           rd_data;
	logic [6:0]           mem_addr;
	logic                 mem_we;
	logic [7:0]           mem_wdata;
	mcsfr_pc_t            pc;
	logic                 w_load;
	logic [7:0]           w_load_value;
	logic [3:0]           wake_enable;
	logic [3:0]           pullup_enable;
	logic                 timer_source_select;
	logic                 timer_edge_select;
	logic                 prescaler_assign;
	logic [3:0]           timer_prescale_log2;
	logic [3:0]           wdt_prescale_log2;
	logic [5:0]           osc_trim_value;
	int                   bad_count;
	int                   cmp_count;

	mcsfr_core i_dut (.clock(clock), .rst(rst), .rst_por(rst_por), .rst_wake(rst_wake),
		.wdt_timeout(wdt_timeout), .op(op), .insn_addr(insn_addr), .insn_lit(insn_lit),
		.w_in(w_in), .alu_operand(alu_operand), .file_addr(file_addr), .file_we(file_we),
		.file_wdata(file_wdata), .flags_upd(flags_upd), .flags_val(flags_val),
		.direction_control(direction_control), .mem_rdata(mem_rdata), .rd_data(rd_data),
		.mem_addr(mem_addr), .mem_we(mem_we), .mem_wdata(mem_wdata), .pc(pc),
		.w_load(w_load), .w_load_value(w_load_value), .wake_enable(wake_enable),
		.pullup_enable(pullup_enable), .timer_source_select(timer_source_select),
		.timer_edge_select(timer_edge_select), .prescaler_assign(prescaler_assign),
		.timer_prescale_log2(timer_prescale_log2), .wdt_prescale_log2(wdt_prescale_log2),
		.osc_trim_value(osc_trim_value));

	////////////////////////////////////////////////////////////////////////////////
	// Clock, 8 ns period
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Cut a hang short; the whole run needs under a hundred cycles
	initial begin
		repeat (3000) @(posedge clock);
		bad_count++;
		test_done();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task test_done();
		if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// Counted comparison, wide enough for every port
	task chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One edge, then back to an idle instruction; inputs move 1 ns after the edge
	task step();
		@(posedge clock);
		#1;
		op = MCSFR_OP_NONE;
		file_we = 1'b0;
		flags_upd = 3'b000;
		wdt_timeout = 1'b0;
	endtask

	task write_reg(input logic [4:0] a, input logic [7:0] d);
		file_addr = a;
		file_we = 1'b1;
		file_wdata = d;
		step();
	endtask

	// Combinational read, looked at off the edge
	task chk_rd(input logic [4:0] a, input logic [7:0] exp);
		file_addr = a;
		#1;
		chk(rd_data, exp);
	endtask

	task do_reset(input logic por, input logic wake);
		rst = 1'b1;
		rst_por = por;
		rst_wake = wake;
		repeat (20) step();
		rst = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Reset values, then the first roll from the last location to zero
	task t_reset();
		chk(pc, 16'h0FFF);
		chk_rd(`MCSFR_ADDR_STATUS, 8'h18);
		chk_rd(`MCSFR_ADDR_TRIM, 8'h80);
		chk_rd(`MCSFR_ADDR_POINTER, 8'hC0);
		chk({wake_enable, pullup_enable}, 16'h0000);
		chk({timer_source_select, timer_edge_select, prescaler_assign}, 16'h0007);
		chk({timer_prescale_log2, wdt_prescale_log2}, 16'h0007);
		step();
		chk(pc, 16'h0000);
		step();
		chk(pc, 16'h0001);
	endtask

	// Every rate under both owners, then the wake, pull-up and source bits
	task t_config();
		for (int a = 0; a < 2; a++) begin
			for (int n = 0; n < 8; n++) begin
				w_in = {4'h0, a[0], n[2:0]};
				op = MCSFR_OP_CONFIG;
				step();
				chk(prescaler_assign, a[0]);
				chk(timer_prescale_log2, a ? 16'h0000 : 16'(n + 1));
				chk(wdt_prescale_log2, a ? 16'(n) : 16'h0000);
			end
		end
		direction_control = 4'b1010;
		w_in = 8'h05;
		op = MCSFR_OP_CONFIG;
		step();
		chk({wake_enable, pullup_enable}, 16'h00AA);
		chk({timer_source_select, timer_edge_select}, 16'h0000);
		w_in = 8'h70;
		op = MCSFR_OP_CONFIG;
		step();
		chk({wake_enable, pullup_enable}, 16'h00A0);
		chk({timer_source_select, timer_edge_select}, 16'h0003);
		w_in = 8'hB0;
		op = MCSFR_OP_CONFIG;
		step();
		chk({wake_enable, pullup_enable}, 16'h000A);
	endtask

	// Page bit into a jump, three calls deep, three returns and a low-latch write
	task t_flow();
		write_reg(`MCSFR_ADDR_STATUS, 8'h20);
		insn_addr = 9'h1AB;
		op = MCSFR_OP_GOTO;
		step();
		chk(pc, 16'h03AB);
		step();
		chk(pc, 16'h03AC);
		insn_lit = 8'h40;
		op = MCSFR_OP_CALL;
		step();
		chk(pc, 16'h0240);
		insn_lit = 8'h10;
		op = MCSFR_OP_CALL;
		step();
		insn_lit = 8'h20;
		op = MCSFR_OP_CALL;
		step();
		chk(pc, 16'h0220);
		insn_lit = 8'h55;
		op = MCSFR_OP_RETURN_LITERAL_INSN;
		step();
		chk(pc, 16'h0211);
		chk({w_load, w_load_value}, 16'h0155);
		insn_lit = 8'h66;
		op = MCSFR_OP_RETURN_LITERAL_INSN;
		step();
		chk(pc, 16'h0241);
		chk({w_load, w_load_value}, 16'h0166);
		op = MCSFR_OP_RETURN_LITERAL_INSN;
		step();
		chk(pc, 16'h0241);
		step();
		chk(w_load, 1'b0);
		write_reg(`MCSFR_ADDR_PC_LOW, 8'h99);
		chk(pc, 16'h0299);
	endtask

	// Pointer through the window, and the window aimed at itself
	task t_indirect();
		write_reg(`MCSFR_ADDR_POINTER, 8'h27);
		chk_rd(`MCSFR_ADDR_POINTER, 8'hA7);
		mem_rdata = 8'h5A;
		file_we = 1'b1;
		file_wdata = 8'h3C;
		chk_rd(`MCSFR_ADDR_INDIRECT, 8'h5A);
		chk({mem_we, mem_addr, mem_wdata}, 16'hA73C);
		step();
		write_reg(`MCSFR_ADDR_POINTER, 8'h71);
		chk_rd(`MCSFR_ADDR_INDIRECT, 8'h5A);
		chk(mem_addr, 7'h71);
		write_reg(`MCSFR_ADDR_POINTER, 8'h60);
		file_we = 1'b1;
		chk_rd(`MCSFR_ADDR_INDIRECT, 8'h00);
		chk(mem_we, 1'b0);
		step();
	endtask

	// Status write masks, computed flags, rotates, power events and trim
	task t_status();
		write_reg(`MCSFR_ADDR_STATUS, 8'hFF);
		chk_rd(`MCSFR_ADDR_STATUS, 8'hBF);
		flags_upd = 3'b111;
		flags_val = 3'b101;
		write_reg(`MCSFR_ADDR_STATUS, 8'h00);
		chk_rd(`MCSFR_ADDR_STATUS, 8'h1D);
		// Zero alone is computed; digit carry and carry must ignore the data
		flags_upd = 3'b100;
		flags_val = 3'b100;
		write_reg(`MCSFR_ADDR_STATUS, 8'h02);
		chk_rd(`MCSFR_ADDR_STATUS, 8'h1D);
		alu_operand = 8'hFE;
		op = MCSFR_OP_RRF;
		step();
		chk_rd(`MCSFR_ADDR_STATUS, 8'h1C);
		alu_operand = 8'h80;
		op = MCSFR_OP_RLF;
		step();
		chk_rd(`MCSFR_ADDR_STATUS, 8'h1D);
		op = MCSFR_OP_SLEEP;
		step();
		chk(rd_data[4:3], 2'b10);
		op = MCSFR_OP_CLRWDT;
		step();
		chk(rd_data[4:3], 2'b11);
		wdt_timeout = 1'b1;
		step();
		chk(rd_data[4:3], 2'b01);
		write_reg(`MCSFR_ADDR_TRIM, 8'hFF);
		chk_rd(`MCSFR_ADDR_TRIM, 8'hFC);
		chk(osc_trim_value, 6'h3F);
		do_reset(1'b0, 1'b1);
		chk_rd(`MCSFR_ADDR_STATUS, 8'h88);
		chk({timer_source_select, wdt_prescale_log2}, 16'h0017);
		chk(pc, 16'h0FFF);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		bad_count = 0;
		cmp_count = 0;
		rst = 1'b1;
		rst_por = 1'b1;
		rst_wake = 1'b0;
		wdt_timeout = 1'b0;
		op = MCSFR_OP_NONE;
		insn_addr = 9'h000;
		insn_lit = 8'h00;
		w_in = 8'h00;
		alu_operand = 8'h00;
		file_addr = 5'h00;
		file_we = 1'b0;
		file_wdata = 8'h00;
		flags_upd = 3'b000;
		flags_val = 3'b000;
		direction_control = 4'hF;
		mem_rdata = 8'h00;
		do_reset(1'b1, 1'b0);
		t_reset();
		t_config();
		t_flow();
		t_indirect();
		t_status();
		test_done();
	end
endmodule
